/* File: core/fcg_intent.sv */
`timescale 1ns/1ps
`default_nettype none
module fcg_intent (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // fault collector and control register side
    input wire logic fsm_in_fault,
    input wire logic [fcg_pkg::FORCE_W-1:0] force_field,
    input wire logic [fcg_pkg::HOLD_W-1:0] hold_units,
    // fault intent
    output logic intent
);

    // ************************************************************
    // state
    // ************************************************************
    localparam logic [fcg_pkg::TICK_W-1:0] TICK_MAX =
        fcg_pkg::TICK_W'(fcg_pkg::HOLD_UNIT_CYCLES - 1);

    typedef struct packed {
        fcg_pkg::fcg_ist_t st;
        logic [fcg_pkg::TICK_W-1:0] tick_cnt;
        logic [fcg_pkg::HOLD_W:0] hold_cnt;
        logic intent;
    } fcg_int_state_t;

    fcg_int_state_t q_ff;
    fcg_int_state_t nxt_q;
    logic raw;
    logic tick;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_q = q_ff;
        // only the internal state counts, never a pad level
        raw = fsm_in_fault || (force_field == fcg_pkg::FORCE_FAULT); // RULE_02 RULE_06 RULE_08
        tick = (q_ff.tick_cnt == TICK_MAX);
        nxt_q.tick_cnt = tick ? '0 : q_ff.tick_cnt + 1'b1;
        case (q_ff.st)
            fcg_pkg::IST_OK: begin
                if (raw) begin
                    nxt_q.st = fcg_pkg::IST_FAULT;
                end
            end
            fcg_pkg::IST_FAULT: begin
                if (!raw) begin
                    if (hold_units != '0) begin
                        // one extra unit: the first tick may come early
                        nxt_q.st = fcg_pkg::IST_HOLD; // RULE_10
                        nxt_q.hold_cnt = {1'b0, hold_units} + 1'b1;
                    end else begin
                        nxt_q.st = fcg_pkg::IST_OK; // RULE_03
                    end
                end
            end
            fcg_pkg::IST_HOLD: begin
                if (raw) begin
                    nxt_q.st = fcg_pkg::IST_FAULT;
                end else if (tick) begin
                    nxt_q.hold_cnt = q_ff.hold_cnt - 1'b1; // RULE_10
                    if (q_ff.hold_cnt == 1) begin
                        nxt_q.st = fcg_pkg::IST_OK; // RULE_03
                    end
                end
            end
            default: begin
                nxt_q.st = fcg_pkg::IST_OK;
            end
        endcase
        nxt_q.intent = (nxt_q.st != fcg_pkg::IST_OK);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign intent = q_ff.intent;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    intent_raise_a: assert property (raw |=> intent) // RULE_02
        else $error("intent not raised after fault cause");
    hold_min_a: assert property ( // RULE_10
        ($fell(raw) && hold_units != '0) |-> intent [*8])
        else $error("fault indication released before hold time");
    hold_end_a: assert property ( // RULE_03
        (q_ff.st == fcg_pkg::IST_HOLD && !raw && tick && q_ff.hold_cnt == 1)
        |=> !intent)
        else $error("intent not released after hold time");
    hold_cv: cover property ($fell(raw) && hold_units != '0 ##[1:1000] !intent);

endmodule
`default_nettype wire

/* File: core/fcg_pkg.sv */
package fcg_pkg;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] OFS_KEEP = 8'h00;
    localparam logic [7:0] OFS_FORCE = 8'h04;
    localparam logic [7:0] OFS_HOLD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_GATED = 8'h10;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int FORCE_W = 2;
    localparam logic [1:0] FORCE_FAULT = 2'h1;
    localparam logic [1:0] FORCE_RST = 2'h0;
    localparam int HOLD_W = 16;
    localparam logic [15:0] HOLD_RST = 16'h000a;
    localparam int ST_INTENT = 0;
    localparam int ST_FSM = 1;
    localparam int ST_FORCE = 2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int HOLD_UNIT_NS = 1000;
    localparam int HOLD_UNIT_CYCLES =
        (HOLD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 5;

    // ************************************************************
    // intent state machine
    // ************************************************************
    typedef enum logic [1:0] {
        IST_OK = 2'b00,
        IST_FAULT = 2'b01,
        IST_HOLD = 2'b10
    } fcg_ist_t;

endpackage

/* File: core/fcg_top.sv */
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - while fault intended, buffers of pins without keep bit switch off
// RULE_02 - intent when collector fsm in fault or forced field is 01b
// RULE_03 - gating released by itself once intent returns to non-fault
// RULE_04 - gating chosen per pin; kept pins go on transmitting
// RULE_05 - pull-up and pull-down settings unchanged while gated
// RULE_06 - gating comes from internal intent, not from pad level
// RULE_07 - gating works even when the fault pad is plain gpio
// RULE_08 - external fault input gates only via collector fault state
// RULE_09 - software should set keep bits for used comm pins, never undriven
// RULE_10 - indication held at fault level a minimum time after clear
// RULE_11 - output enable is normal enable and (keep or no intent), registered
module fcg_top #(
    parameter int NUM_PINS = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // fault collector
    input wire logic fsm_in_fault,
    output logic fault_intent,
    // pad configuration and transmit enables
    input wire logic [NUM_PINS-1:0] pin_oe_in,
    input wire logic [NUM_PINS-1:0] pin_pull_en_in,
    input wire logic [NUM_PINS-1:0] pin_pull_sel_in,
    output logic [NUM_PINS-1:0] pin_oe_out,
    output logic [NUM_PINS-1:0] pin_pull_en_out,
    output logic [NUM_PINS-1:0] pin_pull_sel_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic wr_pend;
        logic [7:0] addr;
        logic [NUM_PINS-1:0] keep;
        logic [fcg_pkg::FORCE_W-1:0] force_f;
        logic [fcg_pkg::HOLD_W-1:0] hold;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] pull_en;
        logic [NUM_PINS-1:0] pull_sel;
        logic [31:0] rdata;
        logic rdy;
        logic resp;
        logic intent_o;
    } fcg_state_t;

    fcg_state_t q_ff;
    fcg_state_t nxt_q;
    logic intent;
    logic aphase;

    function automatic logic fcg_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ************************************************************
    // intent source
    // ************************************************************
    // no pad input exists here, so a gpio-muxed fault pad cannot mask it
    fcg_intent fcg_intent_inst ( // RULE_07
        .hclk(hclk),
        .hresetn(hresetn),
        .fsm_in_fault(fsm_in_fault),
        .force_field(q_ff.force_f),
        .hold_units(q_ff.hold),
        .intent(intent)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_q = q_ff;
        aphase = hsel && htrans[1] && hready;
        // data phase of a write
        if (q_ff.wr_pend) begin
            if (fcg_hit(q_ff.addr, fcg_pkg::OFS_KEEP)) begin
                nxt_q.keep = hwdata[NUM_PINS-1:0]; // RULE_04
            end else if (fcg_hit(q_ff.addr, fcg_pkg::OFS_FORCE)) begin
                nxt_q.force_f = hwdata[fcg_pkg::FORCE_W-1:0]; // RULE_02
            end else if (fcg_hit(q_ff.addr, fcg_pkg::OFS_HOLD)) begin
                nxt_q.hold = hwdata[fcg_pkg::HOLD_W-1:0]; // RULE_10
            end
        end
        nxt_q.wr_pend = aphase && hwrite;
        nxt_q.addr = aphase ? haddr[7:0] : q_ff.addr;
        // keep, force and hold read from the updated copy, so a write just ahead is seen; status and gated use the registered copy
        nxt_q.rdata = 32'h0;
        if (aphase && !hwrite) begin
            if (fcg_hit(haddr[7:0], fcg_pkg::OFS_KEEP)) begin
                nxt_q.rdata[NUM_PINS-1:0] = nxt_q.keep;
            end else if (fcg_hit(haddr[7:0], fcg_pkg::OFS_FORCE)) begin
                nxt_q.rdata[fcg_pkg::FORCE_W-1:0] = nxt_q.force_f;
            end else if (fcg_hit(haddr[7:0], fcg_pkg::OFS_HOLD)) begin
                nxt_q.rdata[fcg_pkg::HOLD_W-1:0] = nxt_q.hold;
            end else if (fcg_hit(haddr[7:0], fcg_pkg::OFS_STATUS)) begin
                nxt_q.rdata[fcg_pkg::ST_INTENT] = intent;
                nxt_q.rdata[fcg_pkg::ST_FSM] = fsm_in_fault;
                nxt_q.rdata[fcg_pkg::ST_FORCE] =
                    (q_ff.force_f == fcg_pkg::FORCE_FAULT);
            end else if (fcg_hit(haddr[7:0], fcg_pkg::OFS_GATED)) begin
                nxt_q.rdata[NUM_PINS-1:0] = ~q_ff.keep & {NUM_PINS{intent}};
            end
        end
        // one extra flop stage trades a cycle of latency for clean enables
        nxt_q.oe = pin_oe_in & (q_ff.keep | {NUM_PINS{~intent}}); // RULE_01 RULE_11
        nxt_q.pull_en = pin_pull_en_in; // RULE_05
        nxt_q.pull_sel = pin_pull_sel_in; // RULE_05
        nxt_q.rdy = 1'b1;
        nxt_q.resp = 1'b0;
        nxt_q.intent_o = intent;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff <= '0;
            q_ff.force_f <= fcg_pkg::FORCE_RST;
            q_ff.hold <= fcg_pkg::HOLD_RST;
            q_ff.rdy <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign hreadyout = q_ff.rdy;
    assign hresp = q_ff.resp;
    assign hrdata = q_ff.rdata;
    assign fault_intent = q_ff.intent_o;
    assign pin_oe_out = q_ff.oe;
    assign pin_pull_en_out = q_ff.pull_en;
    assign pin_pull_sel_out = q_ff.pull_sel;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    gate_off_a: assert property ($past(intent) |-> // RULE_01
        ((pin_oe_out & ~$past(q_ff.keep)) == '0))
        else $error("ungated pin drives during fault");
    keep_on_a: assert property ($past(intent) |-> // RULE_04
        ((pin_oe_out & $past(q_ff.keep)) ==
         ($past(pin_oe_in) & $past(q_ff.keep))))
        else $error("kept pin lost its enable during fault");
    // outputs sit at zero for one edge after reset, so skip that edge
    release_a: assert property ( // RULE_03
        ($past(hresetn) && !$past(intent)) |->
        (pin_oe_out == $past(pin_oe_in)))
        else $error("enable not released without fault intent");
    pull_kept_a: assert property ( // RULE_05
        $past(hresetn) |->
        (pin_pull_en_out == $past(pin_pull_en_in)) &&
        (pin_pull_sel_out == $past(pin_pull_sel_in)))
        else $error("pull setting altered");
    force_gate_a: assert property ( // RULE_02
        (q_ff.force_f == fcg_pkg::FORCE_FAULT) |-> ##2 fault_intent)
        else $error("forced fault did not raise intent");
    fsm_gate_a: assert property (fsm_in_fault |-> ##2 fault_intent) // RULE_08
        else $error("collector fault state did not raise intent");
    cause_a: assert property ($rose(intent) |-> // RULE_06
        ($past(fsm_in_fault) ||
         $past(q_ff.force_f) == fcg_pkg::FORCE_FAULT))
        else $error("intent raised without internal cause");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    force_write_a: assert property ( // RULE_02
        (q_ff.wr_pend && fcg_hit(q_ff.addr, fcg_pkg::OFS_FORCE)) |=>
        (q_ff.force_f == $past(hwdata[fcg_pkg::FORCE_W-1:0])))
        else $error("forced field write lost");
    intent_out_a: assert property ( // RULE_06
        fault_intent == $past(intent))
        else $error("fault indication does not follow internal intent");

    // ************************************************************
    // register bus checks
    // ************************************************************
    keep_write_a: assert property ( // RULE_04
        (q_ff.wr_pend && fcg_hit(q_ff.addr, fcg_pkg::OFS_KEEP)) |=>
        (q_ff.keep == $past(hwdata[NUM_PINS-1:0])))
        else $error("keep bits write lost");
    hold_write_a: assert property ( // RULE_10
        (q_ff.wr_pend && fcg_hit(q_ff.addr, fcg_pkg::OFS_HOLD)) |=>
        (q_ff.hold == $past(hwdata[fcg_pkg::HOLD_W-1:0])))
        else $error("hold time write lost");
    rdata_idle_a: assert property (
        !($past(aphase) && !$past(hwrite)) |-> (hrdata == '0))
        else $error("read data left on bus outside data phase");
    status_read_a: assert property ( // RULE_02
        ($past(aphase) && !$past(hwrite) &&
         fcg_hit($past(haddr[7:0]), fcg_pkg::OFS_STATUS)) |->
        (hrdata[fcg_pkg::ST_FSM] == $past(fsm_in_fault)))
        else $error("status does not show collector state");
    gated_read_a: assert property ( // RULE_01
        ($past(aphase) && !$past(hwrite) &&
         fcg_hit($past(haddr[7:0]), fcg_pkg::OFS_GATED)) |->
        (hrdata[NUM_PINS-1:0] ==
         (~$past(q_ff.keep) & {NUM_PINS{$past(intent)}})))
        else $error("gated pin readback wrong");

    // ************************************************************
    // coverage
    // ************************************************************
    gate_cv: cover property (intent && (q_ff.keep != '0) &&
        ((pin_oe_in & ~q_ff.keep) != '0));
    release_cv: cover property ($fell(intent) ##2 (pin_oe_out != '0));
    force_cv: cover property (q_ff.wr_pend &&
        fcg_hit(q_ff.addr, fcg_pkg::OFS_FORCE));
    fsm_gate_cv: cover property ($rose(fsm_in_fault) ##2
        (pin_oe_out != pin_oe_in));

endmodule
`default_nettype wire

/* File: verif/fcg_fc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcg_fc_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // external fault input and software control
    input wire logic pad_level,
    input wire logic pad_event_en,
    input wire logic sw_set,
    input wire logic sw_clr,
    // collector state
    output logic fsm_in_fault
);
    // ************************************************************
    // collector state machine
    // ************************************************************
    // a pulled-up pad alone is no fault: only an enabled event counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fsm_in_fault <= 1'b0;
        end else if (sw_clr) begin
            fsm_in_fault <= 1'b0;
        end else if (sw_set || (pad_level && pad_event_en)) begin
            fsm_in_fault <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: verif/fcg_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fcg_top_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic fsm_in_fault, fault_intent, pad_level, pad_event_en;
    logic sw_set, sw_clr;
    logic [7:0] oe_in, pe_in, ps_in, oe_out, pe_out, ps_out;
    int failures, samples_checked, n, f;

    assign hready = hreadyout;

    fcg_top #(.NUM_PINS(8)) fcg_top_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fsm_in_fault(fsm_in_fault), .fault_intent(fault_intent),
        .pin_oe_in(oe_in), .pin_pull_en_in(pe_in),
        .pin_pull_sel_in(ps_in), .pin_oe_out(oe_out),
        .pin_pull_en_out(pe_out), .pin_pull_sel_out(ps_out));

    fcg_fc_model fcg_fc_model_inst (.hclk(hclk), .hresetn(hresetn),
        .pad_level(pad_level), .pad_event_en(pad_event_en),
        .sw_set(sw_set), .sw_clr(sw_clr), .fsm_in_fault(fsm_in_fault));

    // ************************************************************
    // clock and watchdog
    // ************************************************************
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // whole run is well under 2000 cycles; ten times that is a hang
    initial begin
        #(40 * 20000);
        failures++;
        close_out();
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pulls must pass through untouched whatever the gating does
    task automatic chk_pins(input logic [7:0] exp_oe, input logic exp_int);
        @(negedge hclk);
        chk({7'h0, fault_intent, oe_out, pe_out, ps_out},
            {7'h0, exp_int, exp_oe, pe_in, ps_in});
    endtask

    task automatic ahb(input logic [7:0] a, input logic wr_en,
                       input logic [31:0] wd);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr_en;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(a, 1'b0, 32'h0);
        chk(rd, exp);
        chk({30'h0, hreadyout, hresp}, 32'h2);
    endtask

    task automatic fc_pulse(input logic s, input logic c);
        @(posedge hclk);
        sw_set <= s;
        sw_clr <= c;
        @(posedge hclk);
        sw_set <= 1'b0;
        sw_clr <= 1'b0;
    endtask

    task automatic wait_int(input logic v);
        for (int i = 0; i < 100 && fault_intent !== v; i++) @(posedge hclk);
        chk({31'h0, fault_intent}, {31'h0, v});
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        oe_in = 8'hff;
        pe_in = 8'h5a;
        ps_in = 8'h33;
        pad_level = 1'b0;
        pad_event_en = 1'b0;
        sw_set = 1'b0;
        sw_clr = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(fcg_pkg::OFS_KEEP, 32'h0);
        rd_chk(fcg_pkg::OFS_FORCE, 32'h0);
        rd_chk(fcg_pkg::OFS_HOLD, {16'h0, fcg_pkg::HOLD_RST});
        rd_chk(fcg_pkg::OFS_STATUS, 32'h0);
        rd_chk(8'h14, 32'h0);
        $display("test reset values done");
        wr(fcg_pkg::OFS_KEEP, 32'h0f);
        wr(fcg_pkg::OFS_HOLD, 32'h0);
        fc_pulse(1'b1, 1'b0);
        wait_int(1'b1);
        chk_pins(8'h0f, 1'b1);
        @(posedge hclk);
        oe_in <= 8'ha5;
        repeat (2) @(posedge hclk);
        chk_pins(8'h05, 1'b1);
        rd_chk(fcg_pkg::OFS_STATUS, 32'h3);
        rd_chk(fcg_pkg::OFS_GATED, 32'hf0);
        fc_pulse(1'b0, 1'b1);
        wait_int(1'b0);
        chk_pins(8'ha5, 1'b0);
        $display("test collector fault done");
        for (f = 0; f < 4; f++) begin
            wr(fcg_pkg::OFS_FORCE, f);
            repeat (4) @(posedge hclk);
            chk_pins(f == 1 ? 8'h05 : 8'ha5, f == 1);
            rd_chk(fcg_pkg::OFS_STATUS, f == 1 ? 32'h5 : 32'h0);
            wr(fcg_pkg::OFS_FORCE, 32'h0);
            wait_int(1'b0);
        end
        $display("test forced field done");
        @(posedge hclk);
        pad_level <= 1'b1;
        repeat (6) @(posedge hclk);
        chk_pins(8'ha5, 1'b0);
        @(posedge hclk);
        pad_event_en <= 1'b1;
        wait_int(1'b1);
        chk_pins(8'h05, 1'b1);
        @(posedge hclk);
        pad_level <= 1'b0;
        pad_event_en <= 1'b0;
        fc_pulse(1'b0, 1'b1);
        wait_int(1'b0);
        $display("test external input done");
        wr(fcg_pkg::OFS_HOLD, 32'h1);
        fc_pulse(1'b1, 1'b0);
        wait_int(1'b1);
        fc_pulse(1'b0, 1'b1);
        repeat (10) @(posedge hclk);
        chk_pins(8'h05, 1'b1);
        n = 12;
        while (fault_intent !== 1'b0 && n < 300) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, n >= fcg_pkg::HOLD_UNIT_CYCLES && n <= 100},
            32'h1);
        chk_pins(8'ha5, 1'b0);
        $display("test hold time done");
        close_out();
    end
endmodule
`default_nettype wire
